// ==== hdl/bhr_regs.vh ====
// Purpose: Constants for the banked host I/O register space
// Assumes: Byte offsets within the 16-byte window, 16-bit word slots
// Notes: Word slot = byte offset / 2
`ifndef BHR_REGS_VH
`define BHR_REGS_VH

// ----------------------------------------------------------------
// Banks
// ----------------------------------------------------------------
`define BHR_BANK0 16'h0000
`define BHR_BANK2 16'h0002
`define BHR_BANK3 16'h0003
`define BHR_BANK4 16'h0004
`define BHR_BANK7 16'h0007
`define BHR_BANK_PKT 16'h0010

// ----------------------------------------------------------------
// Word slots (byte offset / 2)
// ----------------------------------------------------------------
`define BHR_SLOT_0X0 3'h0
`define BHR_SLOT_0X2 3'h1
`define BHR_SLOT_0X4 3'h2
`define BHR_SLOT_0X6 3'h3
`define BHR_SLOT_0X8 3'h4
`define BHR_SLOT_0XA 3'h5
`define BHR_SLOT_0XC 3'h6
`define BHR_SLOT_SEL 3'h7
`define BHR_DWORD_PKT 2'h0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BHR_RST_WORD 16'h0000
`define BHR_RST_BANK 16'h0000

// ----------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------
`define BHR_CFG_BUS_WIDTH 0
`define BHR_CFG_CLK_RATE 1
`define BHR_CFG_LIGHT_DOZE 9
`define BHR_CFG_DEEP_DOZE 10
`define BHR_CFG_PME_D1 11
`define BHR_CFG_PME_D2 12

// ----------------------------------------------------------------
// Power capability register fields
// ----------------------------------------------------------------
`define BHR_PCAP_BUS_WIDTH 0
`define BHR_PCAP_LIGHT_DOZE 9
`define BHR_PCAP_DEEP_DOZE 10
`define BHR_PCAP_PME_D1 12
`define BHR_PCAP_PME_D2 13

// ----------------------------------------------------------------
// Loopback control fields
// ----------------------------------------------------------------
`define BHR_PHYCTRL_LOOP 1
`define BHR_SPECIAL_LOOP 9

`endif

// ==== hdl/bhr_cfg_loop.v ====
// Purpose: Configuration word capture and port one near-end loopback
// Assumes: i_cfg_load pulses once when the serial ROM word is read
// Notes: All outputs registered
`include "bhr_regs.vh"

module bhr_cfg_loop #(
  parameter DW = 4
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire [15:0] i_cfg_word,
  input wire i_cfg_load,
  input wire i_bus_is_32,
  input wire [15:0] i_port_one_phy_control,
  input wire [15:0] i_port_one_special_cable_control,
  input wire [DW-1:0] i_port_one_receive_pair,
  input wire [DW-1:0] i_mac_tx_data,
  output reg o_clock_slow_ff,
  output reg o_bus_16bit_ff,
  output reg [15:0] o_power_capability_ff,
  output reg o_loopback_ff,
  output reg o_force_100_full_ff,
  output reg [DW-1:0] o_port_one_transmit_pair_ff
);

  wire loop_req;
  reg [15:0] nxt_pcap;

  // ----------------------------------------------------------------
  // Loopback request
  // ----------------------------------------------------------------
  assign loop_req = i_port_one_phy_control[`BHR_PHYCTRL_LOOP] |
    i_port_one_special_cable_control[`BHR_SPECIAL_LOOP];

  // ----------------------------------------------------------------
  // Power capability image
  // ----------------------------------------------------------------
  always @* begin
    nxt_pcap = 16'h0000;
    nxt_pcap[`BHR_PCAP_DEEP_DOZE] = i_cfg_word[`BHR_CFG_DEEP_DOZE];
    nxt_pcap[`BHR_PCAP_LIGHT_DOZE] = i_cfg_word[`BHR_CFG_LIGHT_DOZE];
    nxt_pcap[`BHR_PCAP_PME_D2] = i_cfg_word[`BHR_CFG_PME_D2];
    nxt_pcap[`BHR_PCAP_PME_D1] = i_cfg_word[`BHR_CFG_PME_D1];
    nxt_pcap[`BHR_PCAP_BUS_WIDTH] = i_bus_is_32 ? 1'b0 : i_cfg_word[`BHR_CFG_BUS_WIDTH];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_clock_slow_ff <= 1'b0;
      o_bus_16bit_ff <= 1'b0;
      o_power_capability_ff <= 16'h0000;
      o_loopback_ff <= 1'b0;
      o_force_100_full_ff <= 1'b0;
      o_port_one_transmit_pair_ff <= {DW{1'b0}};
    end else begin
      if (i_cfg_load) begin
        o_clock_slow_ff <= i_cfg_word[`BHR_CFG_CLK_RATE];
        o_bus_16bit_ff <= i_cfg_word[`BHR_CFG_BUS_WIDTH];
        o_power_capability_ff <= nxt_pcap;
      end
      o_loopback_ff <= loop_req;
      o_force_100_full_ff <= loop_req;
      o_port_one_transmit_pair_ff <= loop_req ? i_port_one_receive_pair : i_mac_tx_data;
    end
  end

endmodule

// ==== hdl/bhr_top.v ====
// Purpose: Banked host I/O register space of a single-port controller
// Assumes: Single-cycle read and write strobes synchronous to i_clk
// Notes: Dword addressed by i_io_addr[3:2], bytes by active-low lanes
//
// Overview of operation
// - The deep doze support bit of the configuration word is copied to capability bit 10.
// - The light doze support bit of the configuration word is copied to capability bit 9.
// - Configuration bit 1 picks the internal clock, 0 for 125 MHz and 1 for 25 MHz.
// - After reset the clock select shows 125 MHz until a loaded word asks for 25 MHz.
// - Configuration bit 0 picks a 16-bit host bus when one and an 8-bit bus when zero.
// - The bus width bit is copied to capability bit 0, which reads zero in a 32-bit variant.
// - While loopback is on the port is forced to 100BASE-TX full duplex.
// - In loopback the port receive data is sent back out of the port transmit outputs.
// - Bit 1 of the port one PHY control word turns loopback on.
// - Bit 9 of the port one special cable control word also turns loopback on.
// - Only 16 byte locations are decoded and the registers are spread over banks.
// - The word at bytes 0xE to 0xF is the bank selector and is present in every bank.
// - The byte lane enables size every access as 8, 16 or 32 bits.
// - A packet data window lets the host move frame contents through the I/O space.
`include "bhr_regs.vh"

module bhr_top #(
  parameter DW = 4
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire [3:0] i_io_addr,
  input wire [3:0] i_byte_lane_enables_n,
  input wire i_io_rd,
  input wire i_io_wr,
  input wire [31:0] i_io_wdata,
  output reg [31:0] o_io_rdata_ff,
  output reg o_io_rvalid_ff,
  input wire [15:0] i_selftest_info,
  input wire [15:0] i_cfg_word,
  input wire i_cfg_load,
  input wire i_bus_is_32,
  input wire [15:0] i_port_one_phy_control,
  input wire [15:0] i_port_one_special_cable_control,
  input wire [DW-1:0] i_port_one_receive_pair,
  input wire [DW-1:0] i_mac_tx_data,
  input wire [31:0] i_pkt_rdata,
  output reg o_pkt_wr_ff,
  output reg o_pkt_rd_ff,
  output reg [31:0] o_pkt_wdata_ff,
  output reg [3:0] o_pkt_lanes_ff,
  output reg [15:0] o_bank_ff,
  output wire o_clock_slow_ff,
  output wire o_bus_16bit_ff,
  output wire o_loopback_ff,
  output wire o_force_100_full_ff,
  output wire [DW-1:0] o_port_one_transmit_pair_ff
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [15:0] base_address_ff;
  reg [15:0] rx_flow_watermark_ff;
  reg [15:0] bus_error_status_ff;
  reg [15:0] burst_length_ff;
  reg [15:0] station_address_low_ff;
  reg [15:0] station_address_mid_ff;
  reg [15:0] station_address_high_ff;
  reg [15:0] internal_bus_control_ff;
  reg [15:0] serial_rom_control_ff;
  reg [15:0] global_reset_ff;
  reg [15:0] wake_ff [0:15];
  wire [15:0] power_capability;
  wire wake_bank;
  wire pkt_hit;
  integer i;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte enables of one word slot for the current access
  function [1:0] slot_be;
    input [2:0] slot;
    input [3:0] addr;
    input [3:0] be_n;
    begin
      if (slot[2:1] != addr[3:2]) begin
        slot_be = 2'b00;
      end else if (slot[0]) begin
        slot_be = ~be_n[3:2];
      end else begin
        slot_be = ~be_n[1:0];
      end
    end
  endfunction

  // Write data of one word slot
  function [15:0] slot_data;
    input [2:0] slot;
    input [31:0] wdata;
    begin
      slot_data = slot[0] ? wdata[31:16] : wdata[15:0];
    end
  endfunction

  // Byte merge of new data into an old word
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] din;
    input [1:0] en;
    begin
      merge16[7:0] = en[0] ? din[7:0] : old[7:0];
      merge16[15:8] = en[1] ? din[15:8] : old[15:8];
    end
  endfunction

  // Write enable for a banked slot
  function [1:0] wr_en;
    input [15:0] bank;
    input [2:0] slot;
    begin
      if (i_io_wr && o_bank_ff == bank) begin
        wr_en = slot_be(slot, i_io_addr, i_byte_lane_enables_n);
      end else begin
        wr_en = 2'b00;
      end
    end
  endfunction

  // Read value of one word slot in the current bank
  function [15:0] slot_value;
    input [2:0] slot;
    begin
      slot_value = 16'h0000;
      if (slot == `BHR_SLOT_SEL) begin
        slot_value = o_bank_ff;
      end else if (wake_bank && !slot[2]) begin
        slot_value = wake_ff[{o_bank_ff[1:0], slot[1:0]}];
      end else begin
        case (o_bank_ff)
          `BHR_BANK0: begin
            case (slot)
              `BHR_SLOT_0X0: slot_value = base_address_ff;
              `BHR_SLOT_0X4: slot_value = rx_flow_watermark_ff;
              `BHR_SLOT_0X6: slot_value = bus_error_status_ff;
              `BHR_SLOT_0X8: slot_value = burst_length_ff;
              default: slot_value = 16'h0000;
            endcase
          end
          `BHR_BANK2: begin
            case (slot)
              `BHR_SLOT_0X0: slot_value = station_address_low_ff;
              `BHR_SLOT_0X2: slot_value = station_address_mid_ff;
              `BHR_SLOT_0X4: slot_value = station_address_high_ff;
              default: slot_value = 16'h0000;
            endcase
          end
          `BHR_BANK3: begin
            case (slot)
              `BHR_SLOT_0X0: slot_value = internal_bus_control_ff;
              `BHR_SLOT_0X2: slot_value = serial_rom_control_ff;
              `BHR_SLOT_0X4: slot_value = i_selftest_info;
              `BHR_SLOT_0X6: slot_value = global_reset_ff;
              `BHR_SLOT_0X8: slot_value = power_capability;
              default: slot_value = 16'h0000;
            endcase
          end
          default: slot_value = 16'h0000;
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign wake_bank = (o_bank_ff >= `BHR_BANK4) && (o_bank_ff <= `BHR_BANK7);
  assign pkt_hit = (o_bank_ff == `BHR_BANK_PKT) && (i_io_addr[3:2] == `BHR_DWORD_PKT);

  // ----------------------------------------------------------------
  // Read data assembly
  // ----------------------------------------------------------------
  // Evaluated at the read edge, so every register it reads is current
  function [31:0] read_word;
    input [3:0] be_n;
    begin
      read_word = 32'h0000_0000;
      if (pkt_hit) begin
        read_word = i_pkt_rdata;
      end else begin
        read_word[15:0] = slot_value({i_io_addr[3:2], 1'b0});
        read_word[31:16] = slot_value({i_io_addr[3:2], 1'b1});
      end
      // Disabled lanes read zero
      read_word[7:0] = be_n[0] ? 8'h00 : read_word[7:0];
      read_word[15:8] = be_n[1] ? 8'h00 : read_word[15:8];
      read_word[23:16] = be_n[2] ? 8'h00 : read_word[23:16];
      read_word[31:24] = be_n[3] ? 8'h00 : read_word[31:24];
    end
  endfunction

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_io_rdata_ff <= 32'h0000_0000;
      o_io_rvalid_ff <= 1'b0;
    end else begin
      o_io_rvalid_ff <= i_io_rd;
      if (i_io_rd) begin
        o_io_rdata_ff <= read_word(i_byte_lane_enables_n);
      end
    end
  end

  // ----------------------------------------------------------------
  // Packet data window
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pkt_wr_ff <= 1'b0;
      o_pkt_rd_ff <= 1'b0;
      o_pkt_wdata_ff <= 32'h0000_0000;
      o_pkt_lanes_ff <= 4'h0;
    end else begin
      o_pkt_wr_ff <= i_io_wr && pkt_hit && (i_byte_lane_enables_n != 4'hF);
      o_pkt_rd_ff <= i_io_rd && pkt_hit && (i_byte_lane_enables_n != 4'hF);
      if ((i_io_wr || i_io_rd) && pkt_hit) begin
        o_pkt_wdata_ff <= i_io_wdata;
        o_pkt_lanes_ff <= ~i_byte_lane_enables_n;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared bank selector
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bank_ff <= `BHR_RST_BANK;
    end else if (i_io_wr) begin
      o_bank_ff <= merge16(o_bank_ff, slot_data(`BHR_SLOT_SEL, i_io_wdata),
        slot_be(`BHR_SLOT_SEL, i_io_addr, i_byte_lane_enables_n));
    end
  end

  // ----------------------------------------------------------------
  // Bank 0 and bank 2
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      base_address_ff <= `BHR_RST_WORD;
      rx_flow_watermark_ff <= `BHR_RST_WORD;
      bus_error_status_ff <= `BHR_RST_WORD;
      burst_length_ff <= `BHR_RST_WORD;
      station_address_low_ff <= `BHR_RST_WORD;
      station_address_mid_ff <= `BHR_RST_WORD;
      station_address_high_ff <= `BHR_RST_WORD;
    end else begin
      base_address_ff <= merge16(base_address_ff, slot_data(`BHR_SLOT_0X0, i_io_wdata),
        wr_en(`BHR_BANK0, `BHR_SLOT_0X0));
      rx_flow_watermark_ff <= merge16(rx_flow_watermark_ff,
        slot_data(`BHR_SLOT_0X4, i_io_wdata), wr_en(`BHR_BANK0, `BHR_SLOT_0X4));
      bus_error_status_ff <= merge16(bus_error_status_ff,
        slot_data(`BHR_SLOT_0X6, i_io_wdata), wr_en(`BHR_BANK0, `BHR_SLOT_0X6));
      burst_length_ff <= merge16(burst_length_ff, slot_data(`BHR_SLOT_0X8, i_io_wdata),
        wr_en(`BHR_BANK0, `BHR_SLOT_0X8));
      station_address_low_ff <= merge16(station_address_low_ff,
        slot_data(`BHR_SLOT_0X0, i_io_wdata), wr_en(`BHR_BANK2, `BHR_SLOT_0X0));
      station_address_mid_ff <= merge16(station_address_mid_ff,
        slot_data(`BHR_SLOT_0X2, i_io_wdata), wr_en(`BHR_BANK2, `BHR_SLOT_0X2));
      station_address_high_ff <= merge16(station_address_high_ff,
        slot_data(`BHR_SLOT_0X4, i_io_wdata), wr_en(`BHR_BANK2, `BHR_SLOT_0X4));
    end
  end

  // ----------------------------------------------------------------
  // Bank 3
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      internal_bus_control_ff <= `BHR_RST_WORD;
      serial_rom_control_ff <= `BHR_RST_WORD;
      global_reset_ff <= `BHR_RST_WORD;
    end else begin
      internal_bus_control_ff <= merge16(internal_bus_control_ff,
        slot_data(`BHR_SLOT_0X0, i_io_wdata), wr_en(`BHR_BANK3, `BHR_SLOT_0X0));
      serial_rom_control_ff <= merge16(serial_rom_control_ff,
        slot_data(`BHR_SLOT_0X2, i_io_wdata), wr_en(`BHR_BANK3, `BHR_SLOT_0X2));
      global_reset_ff <= merge16(global_reset_ff, slot_data(`BHR_SLOT_0X6, i_io_wdata),
        wr_en(`BHR_BANK3, `BHR_SLOT_0X6));
    end
  end

  // ----------------------------------------------------------------
  // Banks 4 to 7 wake patterns
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (i = 0; i < 16; i = i + 1) begin
        wake_ff[i] <= `BHR_RST_WORD;
      end
    end else if (i_io_wr && wake_bank) begin
      for (i = 0; i < 16; i = i + 1) begin
        if (i[3:2] == o_bank_ff[1:0]) begin
          wake_ff[i] <= merge16(wake_ff[i], slot_data({1'b0, i[1:0]}, i_io_wdata),
            slot_be({1'b0, i[1:0]}, i_io_addr, i_byte_lane_enables_n));
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration and loopback
  // ----------------------------------------------------------------
  bhr_cfg_loop #(
    .DW(DW)
  ) u_cfg_loop (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_cfg_word(i_cfg_word),
    .i_cfg_load(i_cfg_load),
    .i_bus_is_32(i_bus_is_32),
    .i_port_one_phy_control(i_port_one_phy_control),
    .i_port_one_special_cable_control(i_port_one_special_cable_control),
    .i_port_one_receive_pair(i_port_one_receive_pair),
    .i_mac_tx_data(i_mac_tx_data),
    .o_clock_slow_ff(o_clock_slow_ff),
    .o_bus_16bit_ff(o_bus_16bit_ff),
    .o_power_capability_ff(power_capability),
    .o_loopback_ff(o_loopback_ff),
    .o_force_100_full_ff(o_force_100_full_ff),
    .o_port_one_transmit_pair_ff(o_port_one_transmit_pair_ff)
  );

endmodule

// ==== sim/bhr_top_sva.sv ====
// Purpose: Port checks for the banked host register space
// Assumes: One clock domain, reset asynchronous and active low
// Notes: Bound to every bhr_top instance
module bhr_top_sva #(
  parameter DW = 4
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire [3:0] i_io_addr,
  input wire [3:0] i_byte_lane_enables_n,
  input wire i_io_rd,
  input wire i_io_wr,
  input wire [31:0] i_io_wdata,
  input wire [31:0] o_io_rdata_ff,
  input wire o_io_rvalid_ff,
  input wire [15:0] i_cfg_word,
  input wire i_cfg_load,
  input wire [15:0] i_port_one_phy_control,
  input wire [15:0] i_port_one_special_cable_control,
  input wire [DW-1:0] i_port_one_receive_pair,
  input wire [DW-1:0] i_mac_tx_data,
  input wire o_pkt_wr_ff,
  input wire [3:0] o_pkt_lanes_ff,
  input wire [15:0] o_bank_ff,
  input wire o_clock_slow_ff,
  input wire o_bus_16bit_ff,
  input wire o_loopback_ff,
  input wire o_force_100_full_ff,
  input wire [DW-1:0] o_port_one_transmit_pair_ff
);
  wire loop_req = i_port_one_phy_control[1] | i_port_one_special_cable_control[9];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // ----------------------------------------------------------------
  // Host bus
  // ----------------------------------------------------------------
  a_read_answer: assert property (i_io_rd |=> o_io_rvalid_ff)
    else $error("read strobe got no answer");
  a_no_stray_answer: assert property (!i_io_rd |=> !o_io_rvalid_ff)
    else $error("answer without read strobe");
  a_lane_off_zero: assert property (i_io_rd && i_byte_lane_enables_n[0] |=>
    o_io_rdata_ff[7:0] == 8'h00) else $error("disabled lane not zero");
  a_bank_write: assert property (i_io_wr && i_io_addr[3:2] == 2'h3 &&
    i_byte_lane_enables_n[3:2] == 2'h0 |=> o_bank_ff == $past(i_io_wdata[31:16]))
    else $error("bank select not written");
  a_bank_hold: assert property (!i_io_wr |=> $stable(o_bank_ff))
    else $error("bank changed without write");
  a_reserved_zero: assert property (i_io_rd && i_io_addr[3:2] == 2'h3 &&
    i_byte_lane_enables_n[1:0] == 2'h0 |=> o_io_rdata_ff[15:0] == 16'h0000)
    else $error("reserved word not zero");
  a_window_write: assert property (i_io_wr && o_bank_ff == 16'h0010 &&
    i_io_addr[3:2] == 2'h0 && i_byte_lane_enables_n != 4'hF |=>
    o_pkt_wr_ff && o_pkt_lanes_ff == ~$past(i_byte_lane_enables_n))
    else $error("window write lost");
  // ----------------------------------------------------------------
  // Configuration and loopback
  // ----------------------------------------------------------------
  a_rate_load: assert property (i_cfg_load |=> o_clock_slow_ff == $past(i_cfg_word[1]))
    else $error("clock rate not loaded");
  a_rate_hold: assert property (!i_cfg_load |=>
    $stable(o_clock_slow_ff) && $stable(o_bus_16bit_ff)) else $error("config changed alone");
  a_width_load: assert property (i_cfg_load |=> o_bus_16bit_ff == $past(i_cfg_word[0]))
    else $error("bus width not loaded");
  a_loop_follow: assert property (i_reset_n |=> o_loopback_ff == $past(loop_req))
    else $error("loopback not following request");
  a_force_full: assert property (o_force_100_full_ff == o_loopback_ff)
    else $error("speed force differs from loopback");
  a_tx_path: assert property (i_reset_n && loop_req == $past(loop_req) |=>
    o_port_one_transmit_pair_ff ==
    ($past(loop_req) ? $past(i_port_one_receive_pair) : $past(i_mac_tx_data)))
    else $error("transmit pair wrong source");
endmodule

bind bhr_top bhr_top_sva #(.DW(DW)) u_sva (.i_clk, .i_reset_n, .i_io_addr,
  .i_byte_lane_enables_n, .i_io_rd, .i_io_wr, .i_io_wdata, .o_io_rdata_ff, .o_io_rvalid_ff,
  .i_cfg_word, .i_cfg_load, .i_port_one_phy_control, .i_port_one_special_cable_control,
  .i_port_one_receive_pair, .i_mac_tx_data, .o_pkt_wr_ff, .o_pkt_lanes_ff, .o_bank_ff,
  .o_clock_slow_ff, .o_bus_16bit_ff, .o_loopback_ff, .o_force_100_full_ff,
  .o_port_one_transmit_pair_ff);

// ==== sim/bhr_host_model.sv ====
// Purpose: Host processor model for the banked register bus
// Assumes: One-cycle strobes, answer the cycle after a read
// Notes: Write data is inverted once the strobe is gone
module bhr_host_model (
  input wire logic i_clk,
  input wire logic i_rvalid,
  input wire logic [31:0] i_rdata,
  output logic [3:0] o_addr,
  output logic [3:0] o_lanes_n,
  output logic o_rd,
  output logic o_wr,
  output logic [31:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_addr = 4'h0;
    o_lanes_n = 4'hF;
    o_rd = 1'h0;
    o_wr = 1'h0;
    o_wdata = 32'h0;
  end
  task automatic wr(input logic [3:0] a, input logic [3:0] ln, input logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_lanes_n <= ln;
    o_wdata <= d;
    o_wr <= 1'h1;
    @(posedge i_clk);
    o_wr <= 1'h0;
    o_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [3:0] ln, output logic [31:0] q,
                    output bit ok);
    int n;
    @(posedge i_clk);
    o_addr <= a;
    o_lanes_n <= ln;
    o_rd <= 1'h1;
    @(posedge i_clk);
    o_rd <= 1'h0;
    ok = 1'h0;
    q = 32'h0;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (i_rvalid === 1'h1) begin
        ok = 1'h1;
        q = i_rdata;
      end else begin
        @(posedge i_clk);
      end
    end
  endtask
endmodule

// ==== sim/bhr_top_tb_top.sv ====
// Purpose: Self-checking bench for the banked register space
// Assumes: Host model drives the bus, bench drives the rest
// Notes: Expectations follow the register map and config fields
module bhr_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'h0;
  logic i_reset_n = 1'h0;
  logic [3:0] i_io_addr, i_byte_lane_enables_n, o_pkt_lanes_ff;
  logic i_io_rd, i_io_wr, o_io_rvalid_ff, o_pkt_wr_ff, o_pkt_rd_ff;
  logic [31:0] i_io_wdata, o_io_rdata_ff, o_pkt_wdata_ff;
  logic [31:0] i_pkt_rdata = 32'hCAFE_F00D;
  logic [15:0] i_selftest_info = 16'h5AA5;
  logic [15:0] i_cfg_word = 16'h0, i_port_one_phy_control = 16'h0, o_bank_ff;
  logic [15:0] i_port_one_special_cable_control = 16'h0;
  logic i_cfg_load = 1'h0, i_bus_is_32 = 1'h0;
  logic [3:0] i_port_one_receive_pair = 4'h0, i_mac_tx_data = 4'h5;
  logic [3:0] o_port_one_transmit_pair_ff;
  logic o_clock_slow_ff, o_bus_16bit_ff, o_loopback_ff, o_force_100_full_ff;
  int failures = 0, tests_run = 0, b, w, i;
  logic [16:0] cfgs [3] = '{17'h1_0401, 17'h0_0000, 17'h0_1E03};
  logic [16:0] c;

  always #2 i_clk = ~i_clk;

  bhr_top #(.DW(4)) i_dut (.i_clk, .i_reset_n, .i_io_addr, .i_byte_lane_enables_n, .i_io_rd,
    .i_io_wr, .i_io_wdata, .o_io_rdata_ff, .o_io_rvalid_ff, .i_selftest_info, .i_cfg_word,
    .i_cfg_load, .i_bus_is_32, .i_port_one_phy_control, .i_port_one_special_cable_control,
    .i_port_one_receive_pair, .i_mac_tx_data, .i_pkt_rdata, .o_pkt_wr_ff, .o_pkt_rd_ff,
    .o_pkt_wdata_ff, .o_pkt_lanes_ff, .o_bank_ff, .o_clock_slow_ff, .o_bus_16bit_ff,
    .o_loopback_ff, .o_force_100_full_ff, .o_port_one_transmit_pair_ff);
  bhr_host_model i_host (.i_clk, .i_rvalid(o_io_rvalid_ff), .i_rdata(o_io_rdata_ff),
    .o_addr(i_io_addr), .o_lanes_n(i_byte_lane_enables_n), .o_rd(i_io_rd), .o_wr(i_io_wr),
    .o_wdata(i_io_wdata));

  // ----------------------------------------------------------------
  // Compare and access tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [3:0] ln, input logic [31:0] exp);
    logic [31:0] q;
    bit ok;
    i_host.rd(a, ln, q, ok);
    if (!ok) begin
      failures++;
      $display("wrong value at %0t: read never answered", $time);
      give_verdict();
    end
    chk_word(q, exp);
  endtask
  task automatic sel(input logic [15:0] bk);
    i_host.wr(4'hC, 4'h3, {bk, 16'h0});
  endtask
  function automatic logic [31:0] pat(input int bk, input int wd);
    return {bk[7:0], 8'h5A, bk[7:0], 8'hC3} ^ {32{wd[0]}};
  endfunction
  function automatic logic [31:0] keep(input int bk, input int wd);
    logic [31:0] d;
    d = pat(bk, wd);
    if (bk == 1) return 32'h0;
    if ((bk == 0 && wd == 0) || (bk == 2 && wd == 1)) return {16'h0, d[15:0]};
    if (bk == 3 && wd == 1) return {d[31:16], 16'h5AA5};
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'h1;
    rdc(4'hC, 4'h3, 32'h0);
    chk_bit(o_clock_slow_ff, 1'h0);
    $display("test reset values done");
    for (b = 0; b < 8; b++) begin
      sel(b[15:0]);
      for (w = 0; w < 2; w++) i_host.wr({w[1:0], 2'h0}, 4'h0, pat(b, w));
    end
    for (b = 0; b < 8; b++) begin
      sel(b[15:0]);
      rdc(4'hC, 4'h3, {b[15:0], 16'h0});
      for (w = 0; w < 2; w++) rdc({w[1:0], 2'h0}, 4'h0, keep(b, w));
      rdc(4'hC, 4'h0, {b[15:0], 16'h0});
    end
    $display("test bank map done");
    sel(16'h0002);
    i_host.wr(4'h0, 4'hD, 32'hFFFF_77FF);
    rdc(4'h0, 4'hE, 32'h0000_00C3);
    rdc(4'h0, 4'h0, 32'h025A_77C3);
    $display("test byte lanes done");
    for (i = 0; i < 3; i++) begin
      c = cfgs[i];
      @(posedge i_clk);
      i_cfg_word <= c[15:0];
      i_bus_is_32 <= c[16];
      i_cfg_load <= 1'h1;
      @(posedge i_clk);
      i_cfg_load <= 1'h0;
      #1;
      chk_bit(o_clock_slow_ff, c[1]);
      chk_bit(o_bus_16bit_ff, c[0]);
      sel(16'h0003);
      rdc(4'h8, 4'hC, {2'h0, c[12], c[11], 1'h0, c[10], c[9], 8'h0, c[0] & ~c[16]});
    end
    $display("test config word done");
    for (i = 0; i < 4; i++) begin
      @(posedge i_clk);
      i_port_one_phy_control <= {14'h0, i[0], 1'h0};
      i_port_one_special_cable_control <= {6'h0, i[1], 9'h0};
      i_port_one_receive_pair <= 4'hA ^ i[3:0];
      repeat (3) @(posedge i_clk);
      #1;
      chk_bit(o_loopback_ff, i != 0);
      chk_bit(o_force_100_full_ff, i != 0);
      chk_word({28'h0, o_port_one_transmit_pair_ff}, i != 0 ? 4'hA ^ i[3:0] : 4'h5);
    end
    $display("test loopback done");
    sel(16'h0010);
    i_host.wr(4'h0, 4'h0, 32'h1234_5678);
    chk_bit(o_pkt_wr_ff, 1'h1);
    chk_word(o_pkt_wdata_ff, 32'h1234_5678);
    chk_word({28'h0, o_pkt_lanes_ff}, 32'hF);
    rdc(4'h0, 4'h0, 32'hCAFE_F00D);
    chk_bit(o_pkt_rd_ff, 1'h1);
    $display("test packet window done");
    @(posedge i_clk);
    i_reset_n <= 1'h0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'h1;
    rdc(4'hC, 4'h3, 32'h0);
    chk_bit(o_clock_slow_ff, 1'h0);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
